//--- dma_partner_model.sv
`timescale 1ns/1ps
module dma_partner_model (
    // request in, strobes and data out
    input  wire logic       mclk,
    input  wire logic       dmaRequestOut,
    input  wire logic       slow,
    output logic            dmaAckN = 1'b1,
    output logic            iowN = 1'b1,
    output logic      [7:0] dmaDataIn = 8'h5A
);
    logic [7:0] seq_ff = 8'hA0;
    logic [2:0] wait_ff = 3'h0;
    always @(posedge mclk) begin
        if (!dmaAckN) begin // one byte per grant; released data lines never keep the byte
            {dmaAckN, iowN} <= 2'b11;
            dmaDataIn <= ~dmaDataIn;
            seq_ff <= seq_ff + 8'h01;
            wait_ff <= 3'h0;
        end else if (dmaRequestOut && wait_ff >= (slow ? 3'h4 : 3'h1)) begin // ack with write strobe
            {dmaAckN, iowN} <= 2'b00;
            dmaDataIn <= seq_ff;
        end else begin
            wait_ff <= dmaRequestOut ? wait_ff + 3'h1 : 3'h0;
        end
    end
endmodule

//--- floppy_ctrl_pkg.sv
package floppy_ctrl_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_DOR      = 8'h00;
    localparam logic [7:0] ADR_RATE     = 8'h04;
    localparam logic [7:0] ADR_STATUS   = 8'h08;
    localparam logic [7:0] ADR_DATA     = 8'h0C;
    localparam logic [7:0] ADR_CFG0     = 8'h10;
    localparam logic [7:0] ADR_TIMING   = 8'h14;
    localparam logic [7:0] ADR_CONFIGURE = 8'h18;
    localparam logic [7:0] ADR_LEVEL    = 8'h1C;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int DOR_RESET_BIT  = 0;
    localparam int DOR_DMA_BIT    = 3;
    localparam int RATE_RESET_BIT = 7;
    localparam int RATE_PD_BIT    = 6;
    localparam int CFG0_IDENT_BIT = 3;
    localparam int CFG0_ENC_BIT   = 2;
    localparam int CFG0_SINGLE_BIT = 1;
    localparam int TIM_DMA_BIT    = 0;
    localparam int CONF_FIFO_BIT  = 4;
    localparam int CONF_POLL_BIT  = 5;
    localparam int ST_RQM_BIT     = 7;
    localparam int ST_DIO_BIT     = 6;
    localparam int ST_NDMA_BIT    = 5;
    localparam int ST_BUSY_BIT    = 4;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CFG0_RST = 8'h02;
    localparam logic [7:0] CONF_RST = 8'h00;
    localparam logic [7:0] TIM_RST  = 8'h00;
    // ----------------------------------------------------------------
    // core answers to a command byte
    // ----------------------------------------------------------------
    localparam logic [1:0] REPLY_MORE   = 2'h0;
    localparam logic [1:0] REPLY_RESULT = 2'h1;
    localparam logic [1:0] REPLY_XREAD  = 2'h2;
    localparam logic [1:0] REPLY_XWRITE = 2'h3;

    typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RESULT} phase_t;
    typedef enum logic [1:0] {MODE_A, MODE_B, MODE_C} opmode_t;
endpackage

//--- floppy_host_phase_fifo_control.sv
`timescale 1ns/1ps
module floppy_host_phase_fifo_control
    import floppy_ctrl_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and resets
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        porRst,
    // wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic      [31:0] wbDatO,
    output logic             wbAck,
    // dma pins
    input  wire logic        dmaAckN,
    input  wire logic        iorN,
    input  wire logic        iowN,
    input  wire logic        tcPin,
    input  wire logic [7:0]  dmaDataIn,
    output logic      [7:0]  dmaDataOut,
    output logic             dmaRequestOut,
    output logic             dmaRequestOeN,
    output logic             controllerInterruptOut,
    output logic             controllerInterruptOeN,
    // drive side
    input  wire logic        densityHigh,
    output logic             densitySelect,
    output logic             pollingActive,
    output logic             powerDown,
    output logic             coreInReset,
    // core command side
    output logic      [7:0]  cmdByte,
    output logic             cmdStrobe,
    input  wire logic        cmdReply,
    input  wire logic [1:0]  cmdReplyCode,
    input  wire logic        resultValid,
    input  wire logic [7:0]  resultByte,
    input  wire logic        resultLast,
    input  wire logic        execDone,
    output logic             execFinished,
    // core data side
    input  wire logic        diskPushValid,
    input  wire logic [7:0]  diskPushData,
    input  wire logic        diskSectorEnd,
    output logic             diskPushReady,
    output logic             diskPopValid,
    output logic      [7:0]  diskPopData,
    input  wire logic        diskPopReady
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int AW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic            dorReset_ff;
    logic            dorDma_ff;
    logic            rateReset_ff;
    logic            pwrDown_ff;
    logic [7:0]      cfg0_ff;
    logic [7:0]      timing_ff;
    logic [7:0]      configure_ff;
    logic            ack_ff;
    logic [31:0]     rdData_ff;
    phase_t          phase_ff;
    logic            cmdWait_ff;
    logic            busy_ff;
    logic            execRead_ff;
    logic            xferReq_ff;
    logic            writeClosed_ff;
    logic            lastLoaded_ff;
    logic            dackSeen_ff;
    logic            resultHave_ff;
    logic            resultIsLast_ff;
    logic [7:0]      resultData_ff;
    logic [7:0]      cmdByte_ff;
    logic            cmdStrobe_ff;
    logic            execFin_ff;
    logic            prevDack_ff;
    logic            prevIor_ff;
    logic            prevIow_ff;
    logic [7:0]      mem [DEPTH];
    logic [AW-1:0]   wrPtr_ff;
    logic [AW-1:0]   rdPtr_ff;
    logic [CW-1:0]   count_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire       busReq    = wbCyc & wbStb;
    wire       busDone   = busReq & ack_ff;
    wire       wrEn      = busDone & wbWe & wbSel[0];
    wire       rdEn      = busDone & ~wbWe;
    wire       coreRst   = srst | dorReset_ff | rateReset_ff;
    wire       hitDor    = wbAdr == ADR_DOR;
    wire       hitRate   = wbAdr == ADR_RATE;
    wire       hitData   = wbAdr == ADR_DATA;
    wire       hitCfg0   = wbAdr == ADR_CFG0;
    wire       hitTim    = wbAdr == ADR_TIMING;
    wire       hitConf   = wbAdr == ADR_CONFIGURE;

    function automatic opmode_t decodeMode(input logic ident, input logic enc);
        if (ident) begin
            decodeMode = MODE_A;
        end else if (enc) begin
            decodeMode = MODE_B;
        end else begin
            decodeMode = MODE_C;
        end
    endfunction

    wire opmode_t mode   = decodeMode(cfg0_ff[CFG0_IDENT_BIT], cfg0_ff[CFG0_ENC_BIT]);
    wire       isModeB   = mode == MODE_B;
    wire       singleXfer = cfg0_ff[CFG0_SINGLE_BIT];
    wire       dmaMode   = timing_ff[TIM_DMA_BIT];
    wire       inExec    = phase_ff == PH_EXEC;
    // fifo held to byte mode outside execution so an illegal command never leaves stale data
    wire       fifoOn    = configure_ff[CONF_FIFO_BIT] & inExec;
    wire [CW-1:0] effDepth = fifoOn ? CW'(DEPTH) : CW'(1);
    wire [CW-1:0] thrBytes = fifoOn ? CW'(configure_ff[3:0]) + CW'(1) : CW'(1);
    wire       fifoEmpty = count_ff == '0;
    wire       fifoFull  = count_ff >= effDepth;

    // terminal count polarity per mode
    wire       tcActive  = isModeB ? ~tcPin : tcPin;
    wire       dackAct   = ~dmaAckN & dmaMode;
    wire       dackEdge  = dackAct & prevDack_ff;
    wire       iorEdge   = ~iorN & prevIor_ff;
    wire       iowEdge   = ~iowN & prevIow_ff;
    // byte mode read strobes on acknowledge alone, which covers verify cycles
    wire       dmaRdStb  = inExec & execRead_ff & (fifoOn ? (dackAct & iorEdge) : dackEdge);
    wire       dmaWrStb  = inExec & ~execRead_ff & dackAct & iowEdge;
    wire       hostRdStb = rdEn & hitData & inExec & execRead_ff & ~dmaMode;
    wire       hostWrStb = wrEn & hitData & inExec & ~execRead_ff & ~dmaMode;
    wire       diskPush  = inExec & execRead_ff & diskPushValid & ~fifoFull;
    wire       diskPop   = inExec & ~execRead_ff & diskPopReady & ~fifoEmpty;
    wire       doPush    = (diskPush | dmaWrStb | hostWrStb) & ~fifoFull;
    wire       doPop     = (dmaRdStb | hostRdStb | diskPop) & ~fifoEmpty;
    wire       tcQual    = tcActive & dackAct;
    wire       lastRdByte = execRead_ff & lastLoaded_ff & (count_ff == CW'(1)) & dmaRdStb;
    wire       lastWrByte = ~execRead_ff & dmaWrStb & tcActive;

    // request levels per direction
    wire       rdTrigger = ~fifoEmpty & ((count_ff >= effDepth - thrBytes + CW'(fifoOn ? 0 : 1))
                           | lastLoaded_ff);
    wire       wrLow     = fifoOn ? (count_ff <= thrBytes) : fifoEmpty;
    wire       wrDrain   = writeClosed_ff & fifoEmpty;
    wire       cmdAccept = wrEn & hitData & (phase_ff == PH_CMD) & ~cmdWait_ff;
    wire       resRead   = rdEn & hitData & (phase_ff == PH_RESULT) & resultHave_ff;

    wire       request_for_master       = (phase_ff == PH_CMD) ? ~cmdWait_ff :
                           (phase_ff == PH_RESULT) ? resultHave_ff :
                           (xferReq_ff & ~dmaMode);
    wire       transfer_direction_bit       = (phase_ff == PH_RESULT) | (inExec & execRead_ff);
    wire [7:0] statusVal = {request_for_master, transfer_direction_bit, inExec & ~dmaMode, busy_ff, 4'h0};
    wire [7:0] dataVal   = (phase_ff == PH_RESULT) ? resultData_ff : mem[rdPtr_ff];

    wire [7:0] rdMux = hitDor   ? {4'h0, dorDma_ff, 2'h0, dorReset_ff} :
                       hitRate  ? {rateReset_ff, pwrDown_ff, 6'h00} :
                       (wbAdr == ADR_STATUS) ? statusVal :
                       hitData  ? dataVal :
                       hitCfg0  ? cfg0_ff :
                       hitTim   ? timing_ff :
                       hitConf  ? configure_ff :
                       (wbAdr == ADR_LEVEL) ? 8'(count_ff) : 8'h00;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_ff    <= 1'b0;
            rdData_ff <= 32'h0000_0000;
        end else begin
            ack_ff    <= busReq & ~ack_ff;
            rdData_ff <= {24'h00_0000, rdMux};
        end
    end

    // ----------------------------------------------------------------
    // reset and mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            dorReset_ff  <= 1'b1;
            dorDma_ff    <= 1'b0;
            rateReset_ff <= 1'b0;
            pwrDown_ff   <= 1'b0;
            cfg0_ff      <= CFG0_RST;
        end else begin
            rateReset_ff <= wrEn & hitRate & wbDatI[RATE_RESET_BIT];
            if (wrEn & hitDor) begin
                dorReset_ff <= wbDatI[DOR_RESET_BIT];
                dorDma_ff   <= wbDatI[DOR_DMA_BIT];
            end
            if (coreRst) begin
                pwrDown_ff <= 1'b0;
            end else if (wrEn & hitRate) begin
                pwrDown_ff <= wbDatI[RATE_PD_BIT];
            end
            if (wrEn & hitCfg0) begin
                cfg0_ff <= {4'h0, wbDatI[3:1], 1'b0};
            end
        end
    end

    // timing setup survives the pin reset, only power-on clears it
    always_ff @(posedge mclk) begin
        if (porRst) begin
            timing_ff <= TIM_RST;
        end else if (wrEn & hitTim) begin
            timing_ff <= {7'h00, wbDatI[TIM_DMA_BIT]};
        end
    end

    always_ff @(posedge mclk) begin
        if (coreRst) begin
            configure_ff <= CONF_RST;
        end else if (wrEn & hitConf) begin
            configure_ff <= {2'h0, wbDatI[5:0]};
        end
    end

    // ----------------------------------------------------------------
    // phase sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (coreRst) begin
            phase_ff        <= PH_CMD;
            cmdWait_ff      <= 1'b0;
            busy_ff         <= 1'b0;
            execRead_ff     <= 1'b0;
            cmdByte_ff      <= 8'h00;
            cmdStrobe_ff    <= 1'b0;
            execFin_ff      <= 1'b0;
            resultHave_ff   <= 1'b0;
            resultIsLast_ff <= 1'b0;
            resultData_ff   <= 8'h00;
        end else begin
            cmdStrobe_ff <= cmdAccept;
            execFin_ff   <= 1'b0;
            if (cmdAccept) begin
                cmdByte_ff <= wbDatI[7:0];
                cmdWait_ff <= 1'b1;
                busy_ff    <= 1'b1;
            end
            unique case (phase_ff)
                PH_CMD: begin
                    if (cmdWait_ff & cmdReply) begin
                        unique case (cmdReplyCode)
                            REPLY_MORE: begin
                                cmdWait_ff <= 1'b0;
                            end
                            REPLY_RESULT: begin
                                phase_ff <= PH_RESULT;
                            end
                            REPLY_XREAD, REPLY_XWRITE: begin
                                phase_ff    <= PH_EXEC;
                                execRead_ff <= cmdReplyCode == REPLY_XREAD;
                            end
                        endcase
                    end
                end
                PH_EXEC: begin
                    if ((execRead_ff & execDone) | (~execRead_ff & wrDrain)) begin
                        phase_ff   <= PH_RESULT;
                        execFin_ff <= 1'b1;
                    end
                end
                PH_RESULT: begin
                    if (resRead) begin
                        resultHave_ff <= 1'b0;
                        if (resultIsLast_ff) begin
                            phase_ff   <= PH_CMD;
                            cmdWait_ff <= 1'b0;
                            busy_ff    <= 1'b0;
                        end
                    end else if (resultValid & ~resultHave_ff) begin
                        resultHave_ff   <= 1'b1;
                        resultData_ff   <= resultByte;
                        resultIsLast_ff <= resultLast;
                    end
                end
                default: begin
                    phase_ff <= PH_CMD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // fifo storage
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (coreRst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (doPush) begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + AW'(1);
            end
            if (doPop) begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + AW'(1);
            end
            count_ff <= count_ff + CW'(doPush) - CW'(doPop);
        end
    end

    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_ff] <= execRead_ff ? diskPushData : (dmaWrStb ? dmaDataIn : wbDatI[7:0]);
        end
    end

    // ----------------------------------------------------------------
    // transfer request
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (coreRst) begin
            xferReq_ff     <= 1'b0;
            writeClosed_ff <= 1'b0;
            lastLoaded_ff  <= 1'b0;
            dackSeen_ff    <= 1'b0;
            prevDack_ff    <= 1'b0;
            prevIor_ff     <= 1'b0;
            prevIow_ff     <= 1'b0;
        end else begin
            prevDack_ff <= ~dackAct;
            prevIor_ff  <= iorN;
            prevIow_ff  <= iowN;
            dackSeen_ff <= dackAct;
            if (!inExec) begin
                xferReq_ff     <= (phase_ff == PH_CMD) & cmdWait_ff & cmdReply & (cmdReplyCode == REPLY_XWRITE);
                writeClosed_ff <= 1'b0;
                lastLoaded_ff  <= 1'b0;
            end else if (execRead_ff) begin
                if (diskPush & diskSectorEnd) begin
                    lastLoaded_ff <= 1'b1;
                end else if (fifoEmpty) begin
                    lastLoaded_ff <= 1'b0;
                end
                if (fifoEmpty | lastRdByte | (dmaMode & tcQual)) begin
                    xferReq_ff <= 1'b0;
                end else if (rdTrigger) begin
                    xferReq_ff <= 1'b1;
                end
            end else begin
                if (tcQual | lastWrByte | (~dmaMode & tcActive)) begin
                    writeClosed_ff <= 1'b1;
                end
                if (writeClosed_ff | tcQual | lastWrByte | fifoFull) begin
                    xferReq_ff <= 1'b0;
                end else if (wrLow) begin
                    xferReq_ff <= 1'b1;
                end
            end
        end
    end

    // single mode masks the request while acknowledge is held; burst ignores it
    wire dmaReqLevel = dmaMode & xferReq_ff & ~(singleXfer & dackSeen_ff);
    // interrupt also drops once a closed write sees count and acknowledge both idle
    wire intLevel    = (~dmaMode & xferReq_ff & ~(writeClosed_ff & ~tcActive & ~dackAct))
                       | ((phase_ff == PH_RESULT) & resultHave_ff);
    wire pinsDriven  = isModeB | dorDma_ff;

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wbAck                  = ack_ff;
    assign wbDatO                 = ack_ff ? rdData_ff : 32'h0000_0000;
    assign dmaDataOut             = mem[rdPtr_ff];
    assign dmaRequestOut          = dmaReqLevel;
    assign dmaRequestOeN          = ~pinsDriven;
    assign controllerInterruptOut = intLevel;
    assign controllerInterruptOeN = ~pinsDriven;
    assign densitySelect          = (mode == MODE_A) ? densityHigh : ~densityHigh;
    assign pollingActive          = ~configure_ff[CONF_POLL_BIT];
    assign powerDown              = pwrDown_ff;
    assign coreInReset            = dorReset_ff | rateReset_ff;
    assign cmdByte                = cmdByte_ff;
    assign cmdStrobe              = cmdStrobe_ff;
    assign execFinished           = execFin_ff;
    assign diskPushReady          = inExec & execRead_ff & ~fifoFull;
    assign diskPopValid           = inExec & ~execRead_ff & ~fifoEmpty;
    assign diskPopData            = mem[rdPtr_ff];
endmodule

//--- floppy_host_phase_fifo_control_checker.sv
`timescale 1ns/1ps
module floppy_host_phase_fifo_control_checker
    import floppy_ctrl_pkg::*;
(
    // watched ports
    input wire logic        mclk, srst, wbWe, wbAck, dmaAckN, dmaRequestOut, dmaRequestOeN,
    input wire logic        controllerInterruptOeN, densityHigh, densitySelect, pollingActive,
    input wire logic        powerDown, coreInReset, cmdStrobe,
    input wire logic [7:0]  wbAdr,
    input wire logic [3:0]  wbSel,
    input wire logic [31:0] wbDatI
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // shadow of the mode bits; a core reset leaves the config register alone
    logic [1:0] modeBits_ff;
    logic       dataWr_ff;
    wire        wrAck = wbAck && wbWe && wbSel[0];
    wire        modeB = modeBits_ff == 2'b01;
    always_ff @(posedge mclk) begin
        dataWr_ff <= wrAck && wbAdr == ADR_DATA;
        if (srst) modeBits_ff <= 2'b00;
        else if (wrAck && wbAdr == ADR_CFG0) modeBits_ff <= wbDatI[3:2];
    end
    chk_reset_quiet: assert property ($fell(srst) |-> !dmaRequestOut && dmaRequestOeN && !powerDown)
        else $error("request or power-down left by reset");
    chk_poll_start: assert property ($fell(srst) |-> pollingActive)
        else $error("polling off after reset");
    chk_dor_hold: assert property ($fell(srst) |-> coreInReset)
        else $error("core not held in reset");
    chk_rate_reset: assert property (wrAck && wbAdr == ADR_RATE && wbDatI[7] |=> coreInReset)
        else $error("rate reset ignored");
    chk_oe_pair: assert property (dmaRequestOeN == controllerInterruptOeN)
        else $error("enables of request and interrupt differ");
    chk_modeb_drive: assert property (modeB && $past(modeB) && !coreInReset |-> !dmaRequestOeN)
        else $error("mode B output floated");
    chk_density_pol: assert property (($stable(modeBits_ff) && $stable(densityHigh))[*2]
        |-> densitySelect == (modeBits_ff[1] ? densityHigh : !densityHigh))
        else $error("density polarity wrong");
    chk_cmd_cause: assert property (cmdStrobe |-> dataWr_ff || $past(dataWr_ff))
        else $error("command strobe without data write");
    cover property (modeB && !dmaRequestOeN);
    cover property (cmdStrobe);
    cover property (dmaRequestOut && !dmaAckN);
endmodule
bind floppy_host_phase_fifo_control floppy_host_phase_fifo_control_checker
    floppy_host_phase_fifo_control_checker_inst (.*);

//--- tb_floppy_host_phase_fifo_control.sv
`timescale 1ns/1ps
module tb_floppy_host_phase_fifo_control;
    import floppy_ctrl_pkg::*;
    logic        mclk = 0, srst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, densityHigh = 0, slow = 0;
    logic        cmdReply = 0, diskPopReady = 0, wbAck, dmaAckN, iowN, dmaRequestOut, dmaRequestOeN;
    logic        densitySelect, coreInReset, cmdStrobe, diskPopValid;
    logic [1:0]  cmdReplyCode = 2'h0;
    logic [7:0]  wbAdr = 8'h00, dmaDataIn, cmdByte, diskPopData;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic [3:0]  wbSel = 4'hF;
    logic        iorN = 1'b1, tcPin = 1'b0, resultValid = 1'b0, resultLast = 1'b0;
    logic [7:0]  resultByte = 8'h00;
    int          bad_count = 0, tests_run = 0, cycles = 0;
    always #25 mclk = ~mclk;
    floppy_host_phase_fifo_control floppy_host_phase_fifo_control_inst (.*, .porRst(srst),
        .dmaDataOut(), .controllerInterruptOut(), .controllerInterruptOeN(),
        .pollingActive(), .powerDown(),
        .execDone(1'b0), .execFinished(), .diskPushValid(1'b0), .diskPushData(8'h00),
        .diskSectorEnd(1'b0), .diskPushReady());
    dma_partner_model dma_partner_model_inst (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // waits for ack without assuming a latency
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, we, adr, 24'h0, d};
        do begin @(posedge mclk); n++; end while (wbAck !== 1'b1 && n < 20);
        chk(n < 20, 1'b1);
        q = wbDatO[7:0];
        {wbCyc, wbStb} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic t_reset();
        logic [7:0] q;
        wb(0, ADR_CFG0, 0, q);
        chk(q, CFG0_RST);
        wb(1, ADR_RATE, 8'h80, q);
        repeat (3) @(posedge mclk);
        wb(0, ADR_RATE, 0, q);
        chk(q & 8'h80, 8'h00);
        chk(coreInReset, 1'b1);
        wb(1, ADR_DOR, 8'h00, q);
        chk(coreInReset, 1'b0);
        wb(0, 8'h40, 0, q);
        chk(q, 8'h00);
    endtask
    task automatic t_modes();
        logic [7:0] q;
        for (int i = 0; i < 3; i++) begin
            wb(1, ADR_CFG0, (i == 0) ? 8'h0A : (i == 1) ? 8'h06 : 8'h02, q);
            densityHigh <= i[0];
            repeat (2) @(posedge mclk);
            chk(densitySelect, i[0] ^ (i != 0));
            chk(dmaRequestOeN, i != 1);
        end
    endtask
    // command byte, then a dma write with the far side fast and slow
    task automatic t_dma();
        logic [7:0] q;
        int n;
        wb(1, ADR_DOR, 8'h08, q);
        wb(1, ADR_TIMING, 8'h01, q);
        wb(0, ADR_STATUS, 0, q);
        chk(q & 8'hC0, 8'h80);
        wb(1, ADR_DATA, 8'h45, q);
        chk(cmdByte, 8'h45);
        wb(0, ADR_STATUS, 0, q);
        chk(q & 8'h80, 8'h00);
        {cmdReplyCode, cmdReply, diskPopReady} <= {REPLY_XWRITE, 2'b11};
        @(posedge mclk);
        cmdReply <= 0;
        for (int k = 0; k < 3; k++) begin
            slow <= k[0];
            n = 0;
            do begin @(posedge mclk); n++; end while (diskPopValid !== 1'b1 && n < 200);
            chk(diskPopData, 8'hA0 + k[7:0]);
        end
        // terminal count with acknowledge closes the write, then one result byte is offered
        tcPin <= 1'b1;
        {resultValid, resultByte, resultLast} <= {1'b1, 8'h5C, 1'b1};
        repeat (30) @(posedge mclk);
        tcPin <= 1'b0;
        wb(0, ADR_STATUS, 0, q);
        chk(q, 8'hD0);
        wb(0, ADR_DATA, 0, q);
        chk(q, 8'h5C);
        resultValid <= 1'b0;
        wb(0, ADR_STATUS, 0, q);
        chk(q, 8'h80);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 0;
        t_reset();
        t_modes();
        t_dma();
        final_report();
    end
endmodule
